// ---- rtl/bprc_pkg.sv ----
// Shared constants and types of the buck regulator protection controller.
// Assumes a single 125 MHz clock and word-aligned AHB-Lite register access.
`default_nettype none

package bprc_pkg;

  // Clock rate, used to turn times into cycle counts
  localparam int CLK_MHZ = 125;

  // Register byte addresses (low address byte decoded)
  localparam logic [7:0] A_CTRL1 = 8'h00;
  localparam logic [7:0] A_CTRL3 = 8'h04;
  localparam logic [7:0] A_SETPT = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0C;

  // control_word_one fields
  localparam int B_RATE = 0;
  localparam int B_FPWM = 2;
  localparam int B_SPREAD = 3;
  localparam int B_DRAIN = 4;
  localparam int B_SWITCHING_ENABLE_BIT = 5;
  localparam int B_RETRY = 6;
  // control_word_three fields
  localparam int B_LOADLINE = 0;

  // Reset values
  localparam logic [1:0] RATE_RST = 2'h2;
  localparam logic FPWM_RST = 1'b0;
  localparam logic SPREAD_RST = 1'b0;
  localparam logic DRAIN_RST = 1'b1;
  localparam logic SWITCHING_ENABLE_BIT_RST = 1'b1;
  localparam logic RETRY_RST = 1'b0;
  localparam logic LOADLINE_RST = 1'b0;
  localparam logic [7:0] SETPT_RST = 8'h50;

  // Overload counting
  localparam logic [5:0] HIC_CNT_MAX = 6'h20;
  localparam logic [5:0] CURRENT_LIMIT_FLAG_CNT_MIN = 6'h04;

  // Times in microseconds and their cycle counts
  localparam int HICCUP_OFF_US = 128;
  localparam int PG_DEGL_US = 40;
  localparam int HIC_OFF_CYC = HICCUP_OFF_US * CLK_MHZ;
  localparam int PG_DEGL_CYC = PG_DEGL_US * CLK_MHZ;

  // Setpoint code size in uV and slew rates in uV/us
  localparam int CODE_UV = 5000;
  localparam int RATE0_UVUS = 10000;
  localparam int RATE1_UVUS = 5000;
  localparam int RATE2_UVUS = 1250;
  localparam int RATE3_UVUS = 500;
  localparam logic [15:0] SS_STEP_CYC = 16'h0040;
  localparam logic [7:0] SPREAD_TOP = 8'hFF;

  // Converter states, Gray along off-soft-run-pause
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_SOFT = 3'h1,
    ST_RUN = 3'h3,
    ST_PAUSE = 3'h2,
    ST_LOCK = 3'h6
  } bprc_state_t;

  // Cycles between setpoint steps for a slew rate select code
  function automatic logic [15:0] rampInterval(input logic [1:0] sel);
    int cyc;
    cyc = 0;
    case (sel)
      2'h0: cyc = CODE_UV * CLK_MHZ / RATE0_UVUS;
      2'h1: cyc = CODE_UV * CLK_MHZ / RATE1_UVUS;
      2'h2: cyc = CODE_UV * CLK_MHZ / RATE2_UVUS;
      default: cyc = CODE_UV * CLK_MHZ / RATE3_UVUS;
    endcase
    return 16'(cyc);
  endfunction : rampInterval

endpackage : bprc_pkg

`default_nettype wire

// ---- rtl/bprc_ramp.sv ----
// Setpoint stepper: walks the internal code toward a target, one code per interval.
// Assumes the caller holds interval stable while run is high.
`default_nettype none

module bprc_ramp (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic restart,
  input wire logic run,
  input wire logic [7:0] target,
  input wire logic [15:0] interval,
  output logic [7:0] level,
  output logic busy
);

  logic [15:0] tick;

  // Busy until the code sits exactly on target
  assign busy = (level != target);

  // One code per interval, so the slope follows the selected rate
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      level <= 8'h00;
      tick <= 16'h0000;
    end else if (restart) begin
      level <= 8'h00;
      tick <= 16'h0000;
    end else if (!run || !busy) begin
      tick <= 16'h0000;
    end else if (tick >= interval - 16'h0001) begin
      tick <= 16'h0000;
      level <= (level < target) ? level + 8'h01 : level - 8'h01;
    end else begin
      tick <= tick + 16'h0001;
    end
  end

endmodule : bprc_ramp

`default_nettype wire

// ---- rtl/bprc_top.sv ----
// Control and protection logic of a synchronous step-down regulator.
// Assumes comparator and pin inputs are already synchronous to sys_clk.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`default_nettype none

module bprc_top #(
  parameter int HIC_OFF_CYC = bprc_pkg::HIC_OFF_CYC,
  parameter int PG_DEGL_CYC = bprc_pkg::PG_DEGL_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic enPin,
  input wire logic modePin,
  input wire logic extClkValid,
  input wire logic supplyLow,
  input wire logic supplyHighTrip,
  input wire logic supplyHighClear,
  input wire logic thermalShut,
  input wire logic cycleEnd,
  input wire logic overLimit,
  input wire logic underLowLimit,
  input wire logic windowOk,
  input wire logic secondaryStrap,
  input wire logic pgIn,
  output logic switchActive,
  output logic hsEnable,
  output logic lsForce,
  output logic forcedPwm,
  output logic syncLock,
  output logic spreadActive,
  output logic [7:0] spreadCode,
  output logic dischargeOn,
  output logic pgOut,
  output logic pgOe,
  output logic ccmAllow,
  output logic [7:0] setpoint,
  output logic slewing,
  output logic loadLine
);

  bprc_pkg::bprc_state_t state;
  bprc_pkg::bprc_state_t next_state;

  // Bus data phase bookkeeping
  logic aValid;
  logic aWrite;
  logic [7:0] aAddr;

  // Software-visible control bits
  logic [1:0] rampSel;
  logic fpwmBit;
  logic spreadEn;
  logic drainEn;
  logic swEnBit;
  logic retryOn;
  logic loadLineBit;
  logic [7:0] setptReg;

  // Settings in effect for the current ramp
  logic [7:0] apTarget;
  logic [1:0] apRate;

  // Protection, power-good, discharge, strap, spread and ramp state
  logic ovloLatch;
  logic hsBlock;
  logic limitSeen;
  logic [5:0] overCnt;
  logic hicFlag;
  logic ilimFlag;
  logic [15:0] pauseCnt;
  logic [15:0] pgCnt;
  logic pgGood;
  logic everOn;
  logic secondary;
  logic strapDone;
  logic spreadDown;
  logic [7:0] rampLevel;
  logic rampBusy;

  // Address phase accepted when selected, non-idle and bus ready
  wire addrTake = hsel & htrans[1] & hready;
  wire [7:0] rdAddr = haddr[7:0];
  wire rdTake = addrTake & ~hwrite;
  wire wrEn = aValid & aWrite;
  wire wrCtrl1 = wrEn & (aAddr == bprc_pkg::A_CTRL1);
  wire wrCtrl3 = wrEn & (aAddr == bprc_pkg::A_CTRL3);
  wire wrSetpt = wrEn & (aAddr == bprc_pkg::A_SETPT);
  wire rdStat = rdTake & (rdAddr == bprc_pkg::A_STATUS);

  // Read words, unused bits zero
  wire [31:0] ctrl1Word = {25'h0000000, retryOn, swEnBit, drainEn, spreadEn, fpwmBit, rampSel};
  wire [31:0] ctrl3Word = {31'h00000000, loadLineBit};
  wire [31:0] setptWord = {24'h000000, setptReg};
  wire [31:0] statWord = {25'h0000000, state, pgGood, slewing, ilimFlag, hicFlag};
  wire [31:0] rdData = (rdAddr == bprc_pkg::A_CTRL1) ? ctrl1Word :
                       (rdAddr == bprc_pkg::A_CTRL3) ? ctrl3Word :
                       (rdAddr == bprc_pkg::A_SETPT) ? setptWord :
                       (rdAddr == bprc_pkg::A_STATUS) ? statWord : 32'h00000000;

  // Fault and enable conditions
  wire fault = supplyLow | ovloLatch | thermalShut;
  wire enabled = enPin & swEnBit;
  wire running = (state == bprc_pkg::ST_SOFT) | (state == bprc_pkg::ST_RUN);
  wire limNow = limitSeen | overLimit;
  wire overloadNow = (overCnt != 6'h00) | hsBlock;
  wire hicTrip = retryOn & running & (overCnt >= bprc_pkg::HIC_CNT_MAX);
  wire ilimTrip = ~retryOn & running & (overCnt >= bprc_pkg::CURRENT_LIMIT_FLAG_CNT_MIN);
  wire pauseDone = (pauseCnt >= 16'(HIC_OFF_CYC - 1));
  wire restartRamp = (next_state == bprc_pkg::ST_SOFT) & (state != bprc_pkg::ST_SOFT);
  wire applyNow = restartRamp | ((state == bprc_pkg::ST_RUN) & ~rampBusy);
  wire [15:0] stepCyc = (state == bprc_pkg::ST_SOFT) ? bprc_pkg::SS_STEP_CYC :
                        bprc_pkg::rampInterval(apRate);
  wire pgRaw = (state == bprc_pkg::ST_RUN) & windowOk & ~fault;
  wire pgDone = (pgCnt >= 16'(PG_DEGL_CYC - 1));
  wire pwmSel = modePin | fpwmBit;
  wire nextSwitch = (next_state == bprc_pkg::ST_SOFT) | (next_state == bprc_pkg::ST_RUN);
  wire drainCause = ~enPin | ~swEnBit | thermalShut | supplyLow | ovloLatch;

  // State sequencing; faults and disable take precedence over the case
  always_comb begin
    next_state = state;
    unique case (state)
      bprc_pkg::ST_OFF: begin
        if (enabled) next_state = bprc_pkg::ST_SOFT;
      end
      bprc_pkg::ST_SOFT: begin
        if (hicTrip) next_state = bprc_pkg::ST_PAUSE;
        else if (!rampBusy) next_state = bprc_pkg::ST_RUN;
      end
      bprc_pkg::ST_RUN: begin
        if (hicTrip) next_state = bprc_pkg::ST_PAUSE;
      end
      bprc_pkg::ST_PAUSE: begin
        if (pauseDone) next_state = bprc_pkg::ST_SOFT;
      end
      bprc_pkg::ST_LOCK: begin
        if (enabled) next_state = bprc_pkg::ST_SOFT;
      end
      default: next_state = bprc_pkg::ST_OFF;
    endcase
    if (fault) next_state = bprc_pkg::ST_LOCK;
    else if (!enabled) next_state = bprc_pkg::ST_OFF;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) state <= bprc_pkg::ST_OFF;
    else state <= next_state;
  end

  // Zero-wait slave: read data is prepared at the address edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aValid <= 1'b0;
      aWrite <= 1'b0;
      aAddr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      aValid <= addrTake;
      aWrite <= hwrite;
      aAddr <= rdAddr;
      hrdata <= rdTake ? rdData : 32'h00000000;
    end
  end

  // Register writes land in the data phase; unmapped writes vanish
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rampSel <= bprc_pkg::RATE_RST;
      fpwmBit <= bprc_pkg::FPWM_RST;
      spreadEn <= bprc_pkg::SPREAD_RST;
      drainEn <= bprc_pkg::DRAIN_RST;
      swEnBit <= bprc_pkg::SWITCHING_ENABLE_BIT_RST;
      retryOn <= bprc_pkg::RETRY_RST;
      loadLineBit <= bprc_pkg::LOADLINE_RST;
      setptReg <= bprc_pkg::SETPT_RST;
    end else begin
      if (wrCtrl1) begin
        rampSel <= hwdata[bprc_pkg::B_RATE +: 2];
        fpwmBit <= hwdata[bprc_pkg::B_FPWM];
        spreadEn <= hwdata[bprc_pkg::B_SPREAD];
        drainEn <= hwdata[bprc_pkg::B_DRAIN];
        swEnBit <= hwdata[bprc_pkg::B_SWITCHING_ENABLE_BIT];
        retryOn <= hwdata[bprc_pkg::B_RETRY];
      end
      if (wrCtrl3) loadLineBit <= hwdata[bprc_pkg::B_LOADLINE];
      if (wrSetpt) setptReg <= hwdata[7:0];
    end
  end

  // Host copies are taken over only between ramps, never in the middle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      apTarget <= bprc_pkg::SETPT_RST;
      apRate <= bprc_pkg::RATE_RST;
    end else if (applyNow) begin
      apTarget <= setptReg;
      apRate <= rampSel;
    end
  end

  // Soft-start from zero and later scaling share one stepper
  bprc_ramp u_ramp (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .restart(restartRamp),
    .run(running),
    .target(apTarget),
    .interval(stepCyc),
    .level(rampLevel),
    .busy(rampBusy)
  );

  // Overvoltage is held until the lower release level is crossed
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) ovloLatch <= 1'b0;
    else if (supplyHighTrip) ovloLatch <= 1'b1;
    else if (supplyHighClear) ovloLatch <= 1'b0;
  end

  // High side stays blocked until current drops below the low limit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) hsBlock <= 1'b0;
    else if (overLimit) hsBlock <= 1'b1;
    else if (underLowLimit) hsBlock <= 1'b0;
  end

  // Consecutive limited cycles; a clean cycle starts the count over
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      limitSeen <= 1'b0;
      overCnt <= 6'h00;
    end else if (!running) begin
      limitSeen <= 1'b0;
      overCnt <= 6'h00;
    end else if (cycleEnd) begin
      limitSeen <= 1'b0;
      if (!limNow) overCnt <= 6'h00;
      else if (overCnt < bprc_pkg::HIC_CNT_MAX) overCnt <= overCnt + 6'h01;
    end else if (overLimit) begin
      limitSeen <= 1'b1;
    end
  end

  // Sticky flags: a new trip beats a clearing read in the same cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hicFlag <= 1'b0;
      ilimFlag <= 1'b0;
    end else begin
      if (hicTrip) hicFlag <= 1'b1;
      else if (rdStat && !overloadNow) hicFlag <= 1'b0;
      if (ilimTrip) ilimFlag <= 1'b1;
      else if (rdStat && !overloadNow) ilimFlag <= 1'b0;
    end
  end

  // Retry pause timer runs only while paused
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) pauseCnt <= 16'h0000;
    else if (state != bprc_pkg::ST_PAUSE) pauseCnt <= 16'h0000;
    else if (!pauseDone) pauseCnt <= pauseCnt + 16'h0001;
  end

  // Rising edge is filtered, falling edge passes at once
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pgCnt <= 16'h0000;
      pgGood <= 1'b0;
    end else if (!pgRaw) begin
      pgCnt <= 16'h0000;
      pgGood <= 1'b0;
    end else if (pgDone) begin
      pgGood <= 1'b1;
    end else begin
      pgCnt <= pgCnt + 16'h0001;
    end
  end

  // Role strap is caught once, just after reset release
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strapDone <= 1'b0;
      secondary <= 1'b0;
    end else if (!strapDone) begin
      strapDone <= 1'b1;
      secondary <= secondaryStrap;
    end
  end

  // Discharge is armed by the first start, then stays armed
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) everOn <= 1'b0;
    else if (running) everOn <= 1'b1;
  end

  // Triangle sweep; the analog side scales full span to plus and minus ten percent
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      spreadCode <= 8'h00;
      spreadDown <= 1'b0;
    end else if (!spreadActive) begin
      spreadCode <= 8'h00;
      spreadDown <= 1'b0;
    end else if (spreadDown) begin
      spreadCode <= spreadCode - 8'h01;
      if (spreadCode == 8'h01) spreadDown <= 1'b0;
    end else begin
      spreadCode <= spreadCode + 8'h01;
      if (spreadCode == bprc_pkg::SPREAD_TOP - 8'h01) spreadDown <= 1'b1;
    end
  end

  // Pin-facing outputs, all registered
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      switchActive <= 1'b0;
      hsEnable <= 1'b0;
      lsForce <= 1'b0;
      forcedPwm <= 1'b0;
      syncLock <= 1'b0;
      spreadActive <= 1'b0;
      dischargeOn <= 1'b0;
      pgOut <= 1'b0;
      pgOe <= 1'b1;
      ccmAllow <= 1'b0;
      setpoint <= 8'h00;
      slewing <= 1'b0;
      loadLine <= 1'b0;
    end else begin
      switchActive <= nextSwitch;
      hsEnable <= nextSwitch & ~hsBlock & ~overLimit;
      lsForce <= nextSwitch & (hsBlock | overLimit);
      forcedPwm <= pwmSel | extClkValid;
      syncLock <= extClkValid;
      spreadActive <= spreadEn & pwmSel & ~extClkValid & nextSwitch;
      dischargeOn <= drainEn & everOn & drainCause;
      pgOut <= 1'b0;
      // Open drain: primary pulls low when not good, secondary until its start-up ends
      pgOe <= secondary ? (state != bprc_pkg::ST_RUN) : ~pgGood;
      if (!running) ccmAllow <= 1'b0;
      else if (pgIn && (state == bprc_pkg::ST_RUN)) ccmAllow <= 1'b1;
      setpoint <= rampLevel;
      slewing <= (state == bprc_pkg::ST_RUN) & rampBusy;
      // Passed straight through; host changes it only while disabled
      loadLine <= loadLineBit;
    end
  end

endmodule : bprc_top

`default_nettype wire

// ---- test/bprc_stage_model.sv ----
// Power stage stand-in: switching cycle ticks, current comparators, power-good wire.
// Assumes the bench drives the overload level; the wire has a pull-up.
`default_nettype none
module bprc_stage_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic overload,
  input wire logic pgOe,
  input wire logic pgOut,
  output logic cycleEnd,
  output logic overLimit,
  output logic underLowLimit,
  output logic goodWire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase;
  // One switching cycle per eight clocks, free running
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      phase <= 3'h0;
    else
      phase <= phase + 3'h1;
  end
  assign cycleEnd = (phase == 3'h7);
  // Current falls below the low limit once overload ends
  assign overLimit = overload;
  assign underLowLimit = !overload;
  // Released wire goes to the pull-up level
  assign goodWire = pgOe ? pgOut : 1'b1;
endmodule : bprc_stage_model
`default_nettype wire

// ---- test/bprc_top_asserts.sv ----
// Concurrent checks on the controller pins.
// Assumes binding onto bprc_top; deglitch check only for a primary device.
`default_nettype none
module bprc_checker #(
  parameter int PG_DEGL_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic modePin,
  input wire logic extClkValid,
  input wire logic supplyLow,
  input wire logic supplyHighTrip,
  input wire logic supplyHighClear,
  input wire logic overLimit,
  input wire logic underLowLimit,
  input wire logic windowOk,
  input wire logic secondaryStrap,
  input wire logic switchActive,
  input wire logic hsEnable,
  input wire logic lsForce,
  input wire logic forcedPwm,
  input wire logic syncLock,
  input wire logic spreadActive,
  input wire logic dischargeOn,
  input wire logic pgOe,
  input wire logic [7:0] setpoint
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  logic everOn;
  logic [15:0] okRun;
  logic [15:0] sinceStep;
  // History counters saturate so long runs never wrap
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      everOn <= 1'b0;
      okRun <= 16'h0000;
      sinceStep <= 16'h0000;
    end else begin
      everOn <= everOn | switchActive;
      okRun <= !windowOk ? 16'h0000 : okRun + {15'h0000, okRun != 16'hFFFF};
      sinceStep <= $changed(setpoint) ? 16'h0000 : sinceStep + {15'h0000, sinceStep != 16'hFFFF};
    end
  end
  sequence ovHold;
    supplyHighTrip ##1 !supplyHighClear [*3];
  endsequence
  sequence oneStep;
    $changed(setpoint) && setpoint != 8'h00;
  endsequence
  chk_pin_forces: assert property ((modePin | extClkValid) |=> forcedPwm)
    else $error("forced PWM missing");
  chk_sync_lock: assert property (extClkValid |=> syncLock && forcedPwm)
    else $error("sync lock missing");
  chk_spread_sync: assert property (extClkValid [*3] |-> !spreadActive)
    else $error("spread while synchronised");
  chk_hs_off: assert property (overLimit |-> ##[1:2] !hsEnable)
    else $error("high side stays on");
  chk_hs_hold: assert property (lsForce && !underLowLimit |=> !hsEnable)
    else $error("high side back too early");
  chk_pg_low: assert property (!switchActive [*3] |-> pgOe)
    else $error("power good released while off");
  chk_pg_delay: assert property ($fell(pgOe) && !secondaryStrap |-> okRun >= PG_DEGL_CYC)
    else $error("power good rose too soon");
  chk_drain_early: assert property (!everOn && !switchActive |-> !dischargeOn)
    else $error("discharge before first enable");
  chk_low_stop: assert property (supplyLow [*3] |-> !switchActive)
    else $error("switching in low supply");
  chk_high_stop: assert property (ovHold |=> !switchActive)
    else $error("switching in high supply");
  chk_step_size: assert property (oneStep |-> sinceStep >= 16'h003C
    && (setpoint == $past(setpoint) + 8'h01 || setpoint == $past(setpoint) - 8'h01))
    else $error("setpoint jumped");
endmodule : bprc_checker
bind bprc_top bprc_checker #(.PG_DEGL_CYC(PG_DEGL_CYC)) i_chk (
  .sys_clk(sys_clk), .nrst(nrst), .modePin(modePin), .extClkValid(extClkValid),
  .supplyLow(supplyLow), .supplyHighTrip(supplyHighTrip), .supplyHighClear(supplyHighClear),
  .overLimit(overLimit), .underLowLimit(underLowLimit), .windowOk(windowOk),
  .secondaryStrap(secondaryStrap), .switchActive(switchActive), .hsEnable(hsEnable),
  .lsForce(lsForce), .forcedPwm(forcedPwm), .syncLock(syncLock),
  .spreadActive(spreadActive), .dischargeOn(dischargeOn), .pgOe(pgOe), .setpoint(setpoint));
`default_nettype wire

// ---- test/tb_top.sv ----
// Bench for the regulator controller: AHB-Lite host tasks, pin stimulus, stage model.
// Assumes shortened pause and deglitch counts; primary device only.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HIC = 50;
  localparam int DEG = 20;
  localparam int LIMIT = 40000;
  localparam logic [7:0] CT1 = bprc_pkg::A_CTRL1, SP = bprc_pkg::A_SETPT, ST = bprc_pkg::A_STATUS;
  logic sys_clk, nrst, hsel, hwrite, hreadyout, hresp, enPin, modePin, extClkValid;
  logic supplyLow, supplyHighTrip, supplyHighClear, thermalShut, windowOk, overload;
  logic cycleEnd, overLimit, underLowLimit, goodWire, switchActive, hsEnable, lsForce;
  logic forcedPwm, syncLock, spreadActive, dischargeOn, pgOut, pgOe, ccmAllow;
  logic slewing, loadLine, rdPhase;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [7:0] spreadCode, setpoint, tgt, prev;
  logic [31:0] expQ[$], mskQ[$];
  int badCount, checked, cyc, n, seed;
  int rateUv[4] = '{10000, 5000, 1250, 500};
  bprc_top #(.HIC_OFF_CYC(HIC), .PG_DEGL_CYC(DEG)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .enPin(enPin), .modePin(modePin),
    .extClkValid(extClkValid), .supplyLow(supplyLow), .supplyHighTrip(supplyHighTrip),
    .supplyHighClear(supplyHighClear), .thermalShut(thermalShut), .cycleEnd(cycleEnd),
    .overLimit(overLimit), .underLowLimit(underLowLimit), .windowOk(windowOk),
    .secondaryStrap(1'b0), .pgIn(goodWire), .switchActive(switchActive),
    .hsEnable(hsEnable), .lsForce(lsForce), .forcedPwm(forcedPwm), .syncLock(syncLock),
    .spreadActive(spreadActive), .spreadCode(spreadCode), .dischargeOn(dischargeOn),
    .pgOut(pgOut), .pgOe(pgOe), .ccmAllow(ccmAllow), .setpoint(setpoint),
    .slewing(slewing), .loadLine(loadLine));
  bprc_stage_model i_stage (.sys_clk(sys_clk), .nrst(nrst), .overload(overload),
    .pgOe(pgOe), .pgOut(pgOut), .cycleEnd(cycleEnd), .overLimit(overLimit),
    .underLowLimit(underLowLimit), .goodWire(goodWire));
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      badCount++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrapUp
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : tick
  // One single transfer; the slave's hreadyout is the bus ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  // Note the expected word for the watcher
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Cycles to the next setpoint step
  task automatic waitSp();
    prev = setpoint;
    n = 0;
    while (setpoint === prev && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : waitSp
  // Overload for exactly k switching cycles, aligned to a cycle end
  task automatic ovl(input int k);
    @(negedge sys_clk);
    while (cycleEnd !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    overload <= 1'b1;
    tick(8 * k);
    overload <= 1'b0;
    tick(16);
  endtask : ovl
  task automatic fault(input int f, input logic v);
    case (f)
      0: supplyLow <= v;
      1: thermalShut <= v;
      2: begin
        supplyHighTrip <= v;
        supplyHighClear <= !v;
      end
      default: enPin <= !v;
    endcase
  endtask : fault
  // Oldest note against each read data phase
  always @(posedge sys_clk) begin
    if (rdPhase && hreadyout === 1'b1 && expQ.size() > 0)
      chk("hrdata", hrdata & mskQ.pop_front(), expQ.pop_front());
    if (hreadyout === 1'b1)
      rdPhase <= hsel & htrans[1] & !hwrite;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      badCount++;
      wrapUp();
    end
  end
  initial begin
    seed = 32'hA350;
    {hsel, hwrite, enPin, modePin, extClkValid, supplyLow, supplyHighTrip} = '0;
    {thermalShut, overload, rdPhase, haddr, hwdata, htrans} = '0;
    {supplyHighClear, windowOk, nrst} = 3'b110;
    tick(5);
    nrst <= 1'b1;
    rd(CT1, 32'h32, 32'hFFFFFFFF);
    rd(bprc_pkg::A_CTRL3, 32'h0, 32'hFFFFFFFF);
    rd(SP, 32'h50, 32'hFFFFFFFF);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    rd(ST, 32'h0, 32'h7F);
    wr(bprc_pkg::A_CTRL3, 32'h1);
    tgt = 8'h04 + 8'($random(seed) & 32'h7);
    wr(SP, 32'(tgt));
    @(negedge sys_clk);
    chk("offState", {dischargeOn, pgOe, loadLine, hresp}, 4'b0110);
    @(posedge sys_clk);
    enPin <= 1'b1;
    n = 0;
    while (setpoint !== tgt && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("startTarget", setpoint, tgt);
    tick(DEG + 10);
    @(negedge sys_clk);
    chk("goodOpen", {pgOut, pgOe, ccmAllow}, 3'b001);
    @(posedge sys_clk);
    windowOk <= 1'b0;
    tick(3);
    windowOk <= 1'b1;
    n = 0;
    while (pgOe !== 1'b0 && n < 500) begin
      @(negedge sys_clk);
      n++;
    end
    chk("goodDelay", n >= DEG && n <= DEG + 4, 1'b1);
    rd(ST, 32'h38, 32'h7C);
    $display("startup test done");
    // Rate written mid-ramp must wait
    for (int r = 0; r < 4; r++) begin
      wr(CT1, 32'h30 | r);
      tgt = tgt + 8'h02;
      wr(SP, 32'(tgt));
      wr(CT1, 32'h30 | ((r + 1) & 3));
      waitSp();
      waitSp();
      chk("stepGap", n, bprc_pkg::CODE_UV * bprc_pkg::CLK_MHZ / rateUv[r]);
      tick(10);
      chk("rampEnd", setpoint, tgt);
    end
    $display("slew test done");
    for (int m = 0; m < 4; m++) begin
      modePin <= m[0];
      wr(CT1, 32'h32 | (m[1] << 2));
      tick(2);
      @(negedge sys_clk);
      chk("forcedPwm", forcedPwm, m[0] | m[1]);
    end
    modePin <= 1'b0;
    wr(CT1, 32'h3E);
    tick(2);
    @(negedge sys_clk);
    prev = spreadCode;
    chk("spreadOn", spreadActive, 1'b1);
    @(negedge sys_clk);
    chk("spreadMoves", spreadCode !== prev, 1'b1);
    @(posedge sys_clk);
    extClkValid <= 1'b1;
    tick(4);
    @(negedge sys_clk);
    chk("syncMode", {syncLock, forcedPwm, spreadActive}, 3'b110);
    @(posedge sys_clk);
    extClkValid <= 1'b0;
    wr(CT1, 32'h32);
    $display("mode test done");
    // Short bursts are not consecutive enough to flag
    ovl(3);
    ovl(3);
    rd(ST, 32'h0, 32'h2);
    overload <= 1'b1;
    tick(48);
    @(negedge sys_clk);
    chk("limitPins", {lsForce, hsEnable, switchActive}, 3'b101);
    rd(ST, 32'h2, 32'h2);
    rd(ST, 32'h2, 32'h2);
    overload <= 1'b0;
    tick(16);
    rd(ST, 32'h2, 32'h2);
    rd(ST, 32'h0, 32'h2);
    $display("limit test done");
    wr(CT1, 32'h72);
    overload <= 1'b1;
    n = 0;
    while (switchActive !== 1'b0 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    while (switchActive !== 1'b1 && n < 1000) begin
      @(negedge sys_clk);
      n++;
      if (n == 10)
        chk("pauseGood", pgOe, 1'b1);
    end
    chk("pauseLen", n >= HIC && n <= HIC + 2, 1'b1);
    rd(ST, 32'h1, 32'h1);
    overload <= 1'b0;
    tick(2000);
    rd(ST, 32'h1, 32'h1);
    rd(ST, 32'h0, 32'h1);
    wr(CT1, 32'h32);
    $display("retry test done");
    for (int f = 0; f < 4; f++) begin
      @(posedge sys_clk);
      fault(f, 1'b1);
      tick(10);
      @(negedge sys_clk);
      chk("faultStop", {switchActive, dischargeOn}, 2'b01);
      @(posedge sys_clk);
      fault(f, 1'b0);
      tick(100);
      @(negedge sys_clk);
      chk("restart", switchActive === 1'b1 && setpoint < tgt, 1'b1);
    end
    tick(1500);
    wr(CT1, 32'h12);
    tick(2);
    @(negedge sys_clk);
    chk("swOffDrain", {switchActive, dischargeOn}, 2'b01);
    wr(CT1, 32'h2);
    tick(2);
    @(negedge sys_clk);
    chk("drainOff", dischargeOn, 1'b0);
    $display("fault test done");
    wrapUp();
  end
endmodule : tb_top
`default_nettype wire
